// ==== hw/excess3_cfg.svh ====
// Purpose: constants of the decimal datapath and residue checker
// Assumes: 100 MHz mclk, 4 us memory cycle
// Notes:   definitions only
`ifndef EXCESS3_CFG_SVH
`define EXCESS3_CFG_SVH

`define CLK_NS 10
`define MEM_CYCLE_NS 4000
`define CLKS_PER_MEM ((`MEM_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)

`define INFO_BITS 25
`define CHECK_BITS 2
`define DIGITS 6
`define DIGIT_BITS 24
`define SIGN_POS 24

`define DEC_ZERO 4'h3
`define BIN_ZERO 4'h0
`define BIN_ONE 4'h1
`define BIN_TWO 4'h2
`define CARRY_IN 4'h1
`define CORR_CARRY 4'h3
`define CORR_NO_CARRY 4'hd
`define EX3_BIAS 4'h3

`define ADJ_LIMIT 4'h5
`define NINE 4'h9
`define MUL_OVERHEAD 6'h07
`define DIV_OVERHEAD 6'h05

`endif

// ==== hw/excess3_pkg.sv ====
// Purpose: types shared by the decimal datapath and its bench
// Assumes: widths are written out here to match excess3_cfg.svh, not taken from it
// Notes:   sign sits above six excess-three digits
package excess3_pkg;

    typedef struct packed {
        logic sign;
        logic [23:0] digits;
        logic [1:0] check;
    } word_type;

    typedef enum logic [1:0] {
        op_add,
        op_sub,
        op_mul,
        op_div
    } op_type;

    typedef struct packed {
        logic valid;
        op_type op;
        word_type reg_word;
        word_type mem_word;
        logic [23:0] quotient;
    } req_type;

    typedef struct packed {
        logic valid;
        word_type word;
    } xfer_type;

    typedef struct packed {
        logic carry;
        logic [23:0] raw;
        logic [23:0] sum;
    } dec_out_type;

    typedef enum logic {
        st_idle,
        st_run
    } state_type;

endpackage : excess3_pkg

// ==== hw/excess3_arith_mod3_check.sv ====
// Purpose: excess-three add/subtract, modulo-3 residue check, and
//          multiply/divide duration from multiplier and quotient
// Assumes: requests come from the sequencer on mclk, never while busy
// Notes:   full multiply/divide digit work lives elsewhere
`timescale 1ns/1ps
`include "excess3_cfg.svh"

module excess3_arith_mod3_check #(
    parameter int CLKS_PER_MEM = `CLKS_PER_MEM
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire excess3_pkg::req_type req,
    input wire excess3_pkg::xfer_type xfer,
    output excess3_pkg::word_type result_q,
    output logic [23:0] second_arith_register_q,
    output logic [5:0] mem_cycles_q,
    output logic recomp_q,
    output logic busy_q,
    output logic done_q,
    output logic mod3_err_q
);

    // ********************************************************
    // arithmetic functions
    // ********************************************************

    function automatic logic [1:0] add3(
        input logic [1:0] a,
        input logic [1:0] b
    );
        logic [2:0] s;
        s = {1'b0, a} + {1'b0, b};
        add3 = (s >= 3'h3) ? 2'(s - 3'h3) : s[1:0];
    endfunction : add3

    function automatic logic [1:0] neg3(input logic [1:0] r);
        neg3 = (r == 2'h0) ? 2'h0 : 2'(2'h3 - r);
    endfunction : neg3

    // remainder of a 25-bit value by weighting set bits
    function automatic logic [1:0] res25(input logic [24:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < `INFO_BITS; i++) begin
            if (v[i]) begin
                r = add3(r, (i % 2 == 0) ? 2'h1 : 2'h2);
            end
        end
        res25 = r;
    endfunction : res25

    // whole word must come out a multiple of three
    function automatic logic word_bad(input excess3_pkg::word_type w);
        word_bad = add3(res25({w.sign, w.digits}), w.check) != 2'h0;
    endfunction : word_bad

    // residue of the digits alone, from the carried check field
    function automatic logic [1:0] digit_res(
        input excess3_pkg::word_type w
    );
        digit_res = add3(neg3(w.check), neg3({1'b0, w.sign}));
    endfunction : digit_res

    function automatic logic [23:0] conv(
        input logic [23:0] d,
        input logic from_mem
    );
        logic [3:0] c;
        conv = d;
        for (int i = 0; i < `DIGITS; i++) begin
            c = d[4*i +: 4];
            if (c == `BIN_ZERO || (from_mem &&
                (c == `BIN_ONE || c == `BIN_TWO))) begin
                conv[4*i +: 4] = `DEC_ZERO;
            end
        end
    endfunction : conv

    function automatic excess3_pkg::dec_out_type dec_core(
        input logic [23:0] a,
        input logic [23:0] b,
        input logic sub
    );
        logic [4:0] s;
        logic c;
        logic [5:0] dc;
        excess3_pkg::dec_out_type o;
        c = 1'b0;
        dc = 6'h00;
        o = '0;
        for (int i = 0; i < `DIGITS; i++) begin
            s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]}
                + {4'h0, c};
            if (i == 0) begin
                s = 5'(s + {1'b0, `CARRY_IN});
            end
            o.raw[4*i +: 4] = s[3:0];
            dc[i] = s[4];
            c = s[4];
        end
        o.carry = c;
        for (int i = 0; i < `DIGITS; i++) begin
            // correction carries never leave their digit
            if (sub ? c : dc[i]) begin
                o.sum[4*i +: 4] = 4'(o.raw[4*i +: 4] + `CORR_CARRY);
            end else begin
                o.sum[4*i +: 4] = 4'(o.raw[4*i +: 4] + `CORR_NO_CARRY);
            end
        end
        dec_core = o;
    endfunction : dec_core

    // binary adder stage agrees with the operand residues
    function automatic logic adder_bad(
        input logic [23:0] a,
        input logic [23:0] b,
        input excess3_pkg::dec_out_type o
    );
        logic [1:0] want;
        want = add3(add3(res25({1'b0, a}), res25({1'b0, b})), 2'h1);
        adder_bad = res25({o.carry, o.raw}) != want;
    endfunction : adder_bad

    // non-numeric codes count as zero for timing
    function automatic logic [3:0] val(input logic [3:0] code);
        val = (code >= `EX3_BIAS && code <= 4'hc) ?
              4'(code - `EX3_BIAS) : 4'h0;
    endfunction : val

    function automatic logic [5:0] mul_cycles(input logic [23:0] m);
        logic [3:0] n;
        logic [3:0] adj;
        logic [3:0] prev;
        logic force_inc;
        logic [5:0] t;
        prev = 4'h0;
        force_inc = 1'b0;
        t = `MUL_OVERHEAD;
        for (int i = 0; i < `DIGITS; i++) begin
            n = val(m[4*i +: 4]);
            adj = n;
            if (i > 0 && (prev >= `ADJ_LIMIT || force_inc)) begin
                adj = (n == `NINE) ? 4'h0 : 4'(n + 4'h1);
            end
            force_inc = (i > 0) && (prev >= `ADJ_LIMIT || force_inc)
                        && (n == `NINE);
            prev = adj;
            case (adj)
                4'h3, 4'h4, 4'h6, 4'h7: t = 6'(t + 6'h3);
                4'h5: t = 6'(t + 6'h4);
                default: t = 6'(t + 6'h2);
            endcase
        end
        mul_cycles = t;
    endfunction : mul_cycles

    function automatic logic [5:0] div_cycles(input logic [23:0] q);
        logic [3:0] n;
        logic [3:0] up;
        logic [5:0] t;
        t = `DIV_OVERHEAD;
        for (int i = 0; i < `DIGITS; i++) begin
            n = val(q[4*i +: 4]);
            up = val(4'(q >> (4 * i + 4)));
            if (i == `DIGITS - 1 || up[0]) begin
                t = 6'(t + ((n < 4'h2) ? 6'h2 : (n < 4'h4) ? 6'h3 :
                            (n < 4'h6) ? 6'h4 : 6'h5));
            end else begin
                t = 6'(t + ((n < 4'h4) ? 6'h5 : (n < 4'h6) ? 6'h4 :
                            (n < 4'h8) ? 6'h3 : 6'h2));
            end
        end
        div_cycles = t;
    endfunction : div_cycles

    // ********************************************************
    // decode, sequencing and results
    // ********************************************************

    logic take;
    logic add_path;
    logic [23:0] a_cv;
    logic [23:0] b_cv;
    excess3_pkg::dec_out_type pass1;
    excess3_pkg::dec_out_type pass2;
    logic need_recomp;
    logic arith_bad;
    logic [5:0] cycles_d;
    excess3_pkg::word_type result_d;
    logic [23:0] zero_word;
    excess3_pkg::state_type state_q;
    logic [15:0] count_q;
    assign take = req.valid && state_q == excess3_pkg::st_idle;
    assign zero_word = {`DIGITS{`DEC_ZERO}};
    assign add_path = (req.op == excess3_pkg::op_add) ==
                      (req.reg_word.sign == req.mem_word.sign);
    assign a_cv = conv(req.reg_word.digits, 1'b0);
    assign b_cv = conv(req.mem_word.digits, 1'b1);
    assign pass1 = dec_core(a_cv, add_path ? b_cv : ~b_cv, !add_path);
    assign pass2 = dec_core(zero_word, ~pass1.sum, 1'b1);
    assign need_recomp = !add_path && !pass1.carry;

    always_comb begin
        arith_bad = word_bad(req.reg_word)
                    || res25({1'b0, b_cv}) != digit_res(req.mem_word);
        arith_bad = arith_bad ||
                    adder_bad(a_cv, add_path ? b_cv : ~b_cv, pass1);
        if (need_recomp) begin
            arith_bad = arith_bad ||
                        adder_bad(zero_word, ~pass1.sum, pass2);
        end
        result_d = req.reg_word;
        cycles_d = 6'h00;
        case (req.op)
            excess3_pkg::op_mul: begin
                cycles_d = mul_cycles(req.reg_word.digits);
                arith_bad = 1'b0;
            end
            excess3_pkg::op_div: begin
                cycles_d = div_cycles(req.quotient);
                arith_bad = 1'b0;
            end
            default: begin
                result_d.digits = need_recomp ? pass2.sum : pass1.sum;
                result_d.sign = req.reg_word.sign ^ need_recomp;
                cycles_d = need_recomp ? 6'h01 : 6'h00;
            end
        endcase
        result_d.check = neg3(res25({result_d.sign, result_d.digits}));
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= excess3_pkg::st_idle;
            count_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                excess3_pkg::st_idle: begin
                    if (take && cycles_d != 6'h00) begin
                        state_q <= excess3_pkg::st_run;
                        busy_q <= 1'b1;
                        count_q <= 16'(32'(cycles_d) * CLKS_PER_MEM - 1);
                    end else if (take) begin
                        done_q <= 1'b1;
                    end
                end
                excess3_pkg::st_run: begin
                    if (count_q == 16'h0000) begin
                        state_q <= excess3_pkg::st_idle;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        count_q <= 16'(count_q - 16'h0001);
                    end
                end
                default: begin
                    state_q <= excess3_pkg::st_idle;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_q <= '0;
            mem_cycles_q <= 6'h00;
            recomp_q <= 1'b0;
        end else if (take) begin
            result_q <= result_d;
            mem_cycles_q <= cycles_d;
            recomp_q <= need_recomp && req.op != excess3_pkg::op_mul
                        && req.op != excess3_pkg::op_div;
        end
    end

    // quotient lands as the divide finishes, not when it starts
    logic [23:0] quot_hold_q;
    logic div_run_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            quot_hold_q <= 24'h000000;
            div_run_q <= 1'b0;
            second_arith_register_q <= 24'h000000;
        end else begin
            if (take) begin
                quot_hold_q <= req.quotient;
                div_run_q <= req.op == excess3_pkg::op_div;
            end
            if (state_q == excess3_pkg::st_run && count_q == 16'h0000
                && div_run_q) begin
                second_arith_register_q <= quot_hold_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mod3_err_q <= 1'b0;
        end else begin
            mod3_err_q <= (xfer.valid && word_bad(xfer.word))
                          || (take && arith_bad);
        end
    end

endmodule : excess3_arith_mod3_check

// ==== verif/excess3_checker.sv ====
// Purpose: port-level timing and residue checks of the decimal datapath
// Assumes: one clock domain, rstn asynchronous active low
// Notes:   attached by the bind after the module
`timescale 1ns/1ps
module excess3_checker #(
    parameter int CLKS_PER_MEM = 2
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire excess3_pkg::req_type req,
    input wire excess3_pkg::xfer_type xfer,
    input wire excess3_pkg::word_type result_q,
    input wire logic [23:0] second_arith_register_q,
    input wire logic [5:0] mem_cycles_q,
    input wire logic recomp_q,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic mod3_err_q
);
    // ****************
    // helpers
    // ****************
    int bcnt_q;
    logic take;
    logic arith;
    assign take = req.valid && !busy_q;
    assign arith = req.op < excess3_pkg::op_mul;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bcnt_q <= 0;
        end else begin
            bcnt_q <= busy_q ? bcnt_q + 1 : 0;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    busy_len_a: assert property (
        $fell(busy_q) |-> bcnt_q == mem_cycles_q * CLKS_PER_MEM)
        else $error("busy span differs from cycle count");
    busy_done_a: assert property (
        $fell(busy_q) |-> done_q)
        else $error("busy ended without done");
    arith_ans_a: assert property (
        take && arith |=> recomp_q ? busy_q && mem_cycles_q == 6'h01
                                   : done_q && mem_cycles_q == 6'h00)
        else $error("add or subtract answer timing wrong");
    mul_hold_a: assert property (
        take && req.op == excess3_pkg::op_mul |=> busy_q &&
        result_q == $past(req.reg_word) && mem_cycles_q inside {[19:31]})
        else $error("multiply start wrong");
    div_span_a: assert property (
        take && req.op == excess3_pkg::op_div |=> busy_q ##0
        mem_cycles_q inside {[17:35]})
        else $error("divide duration out of range");
    quot_load_a: assert property (
        $changed(second_arith_register_q) |-> done_q)
        else $error("quotient moved outside completion");
    sum_check_a: assert property (
        done_q && mem_cycles_q == 6'h00 |->
        ({result_q.sign, result_q.digits} % 3 + result_q.check) % 3 == 0)
        else $error("result check bits wrong");
    xfer_err_a: assert property (
        xfer.valid && ({xfer.word.sign, xfer.word.digits} % 3
        + xfer.word.check) % 3 != 0 |=> mod3_err_q)
        else $error("bad transfer not flagged");
    err_cause_a: assert property (
        mod3_err_q |-> $past(xfer.valid) || $past(take && arith))
        else $error("error flag without cause");
    cover property (take && req.op == excess3_pkg::op_mul);
    cover property (done_q && recomp_q);
    cover property (mod3_err_q);
endmodule : excess3_checker

bind excess3_arith_mod3_check excess3_checker #(
    .CLKS_PER_MEM(CLKS_PER_MEM)
) u_chk (
    .mclk(mclk), .rstn(rstn), .req(req), .xfer(xfer),
    .result_q(result_q), .second_arith_register_q(second_arith_register_q),
    .mem_cycles_q(mem_cycles_q), .recomp_q(recomp_q), .busy_q(busy_q),
    .done_q(done_q), .mod3_err_q(mod3_err_q)
);

// ==== verif/seq_model.sv ====
// Purpose: sequencer stand-in presenting operations to the datapath
// Assumes: the bench offers at most one command per cycle
// Notes:   a command offered while busy is dropped, never queued
`timescale 1ns/1ps
module seq_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic busy_q,
    input wire excess3_pkg::req_type cmd,
    output excess3_pkg::req_type req
);
    // ****************
    // issue
    // ****************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            req <= '0;
        end else if (cmd.valid && !busy_q) begin
            req <= cmd;
        end else begin
            req <= '0;
        end
    end
endmodule : seq_model

// ==== verif/excess3_arith_mod3_check_test.sv ====
// Purpose: self-checking bench of the decimal datapath
// Assumes: CLKS_PER_MEM shortened to 2
// Notes:   driver queues expectations, monitor checks them on done_q
`timescale 1ns/1ps
module excess3_arith_mod3_check_test;
    typedef struct {
        excess3_pkg::word_type res;
        logic [23:0] quo;
        logic [5:0] cyc;
        logic rc;
        logic err;
        excess3_pkg::op_type op;
    } exp_type;
    logic mclk = 1'b0;
    logic rstn = 1'b1;
    excess3_pkg::req_type cmd = '0;
    excess3_pkg::req_type req;
    excess3_pkg::xfer_type xfer = '0;
    excess3_pkg::word_type result_q;
    logic [23:0] second_arith_register_q;
    logic [5:0] mem_cycles_q;
    logic recomp_q, busy_q, done_q, mod3_err_q;
    int errors = 0;
    int samples_checked = 0;
    exp_type eq[$];
    logic xq[$];
    logic xpend = 1'b0;
    always #5 mclk = ~mclk;
    seq_model u_seq (.mclk(mclk), .rstn(rstn), .busy_q(busy_q),
        .cmd(cmd), .req(req));
    excess3_arith_mod3_check #(.CLKS_PER_MEM(2)) u_dut (
        .mclk(mclk), .rstn(rstn), .req(req), .xfer(xfer),
        .result_q(result_q), .second_arith_register_q(second_arith_register_q),
        .mem_cycles_q(mem_cycles_q), .recomp_q(recomp_q), .busy_q(busy_q),
        .done_q(done_q), .mod3_err_q(mod3_err_q));
    // ****************
    // reference model
    // ****************
    function automatic int dv(logic [3:0] c);
        return (c > 4'h2 && c < 4'hd) ? int'(c) - 3 : 0;
    endfunction : dv
    function automatic logic [1:0] chk(logic [24:0] v);
        return 2'((3 - v % 3) % 3);
    endfunction : chk
    function automatic excess3_pkg::word_type mk(logic s, logic [23:0] d);
        return {s, d, chk({s, d})};
    endfunction : mk
    function automatic logic [23:0] nd();
        logic [23:0] d;
        for (int i = 0; i < 6; i++) d[4*i+:4] = 4'($urandom % 10) + 4'h3;
        return d;
    endfunction : nd
    function automatic logic [23:0] cv(logic [23:0] d, logic m);
        for (int i = 0; i < 6; i++)
            if (d[4*i+:4] == 4'h0 || (m && d[4*i+:4] < 4'h3)) d[4*i+:4] = 4'h3;
        return d;
    endfunction : cv
    function automatic logic [24:0] dad(logic [23:0] a, logic [23:0] b,
                                        logic s);
        logic [4:0] t;
        logic [23:0] w;
        logic [5:0] cy;
        logic c;
        c = 1'b1;
        b = s ? ~b : b;
        for (int i = 0; i < 6; i++) begin
            t = a[4*i+:4] + b[4*i+:4] + c;
            c = t[4];
            cy[i] = t[4];
            w[4*i+:4] = t[3:0];
        end
        for (int i = 0; i < 6; i++)
            w[4*i+:4] += ((s ? c : cy[i]) ? 4'h3 : 4'hd);
        return {c, w};
    endfunction : dad
    function automatic logic [5:0] mcy(logic [23:0] d);
        int t;
        int n;
        int inc;
        t = 7;
        inc = 0;
        for (int i = 0; i < 6; i++) begin
            n = dv(d[4*i+:4]) + inc;
            inc = n >= 5;
            n = n % 10;
            t += (n == 5) ? 4 : (n inside {3, 4, 6, 7}) ? 3 : 2;
        end
        return 6'(t);
    endfunction : mcy
    function automatic logic [5:0] dcy(logic [23:0] d);
        int t;
        int q;
        t = 5;
        for (int i = 0; i < 6; i++) begin
            q = dv(d[4*i+:4]);
            if (i == 5 || dv(d[4*i+4+:4]) % 2)
                t += q < 2 ? 2 : q < 4 ? 3 : q < 6 ? 4 : 5;
            else
                t += q < 4 ? 5 : q < 6 ? 4 : q < 8 ? 3 : 2;
        end
        return 6'(t);
    endfunction : dcy
    // ****************
    // drivers and monitor
    // ****************
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (exp !== got) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic issue(excess3_pkg::req_type r);
        exp_type e;
        logic [24:0] w;
        logic [23:0] b;
        logic sub;
        int n;
        e = '{r.reg_word, r.quotient, 6'h00, 1'b0, 1'b0, r.op};
        sub = (r.op == excess3_pkg::op_sub) ^
              (r.reg_word.sign != r.mem_word.sign);
        b = cv(r.mem_word.digits, 1'b1);
        w = dad(cv(r.reg_word.digits, 1'b0), b, sub);
        if (r.op == excess3_pkg::op_mul) begin
            e.cyc = mcy(r.reg_word.digits);
        end else if (r.op == excess3_pkg::op_div) begin
            e.cyc = dcy(r.quotient);
        end else begin
            if (sub && !w[24]) begin
                w = dad(24'h333333, w[23:0], 1'b1);
                e.rc = 1'b1;
                e.cyc = 6'h01;
            end
            e.res = mk(r.reg_word.sign ^ e.rc, w[23:0]);
            e.err = chk({r.mem_word.sign, b}) != r.mem_word.check;
        end
        eq.push_back(e);
        @(posedge mclk);
        cmd <= r;
        if (e.cyc != 6'h00) begin
            @(posedge mclk);
            cmd.valid <= 1'b0;
            repeat (2) @(posedge mclk);
            n = 0;
            while (busy_q && n++ < 500) @(posedge mclk);
            check("busy", 0, busy_q);
        end
    endtask : issue
    task automatic send(excess3_pkg::word_type w);
        xq.push_back(({w.sign, w.digits} % 3 + w.check) % 3 != 0);
        @(posedge mclk);
        xfer <= {1'b1, w};
        @(posedge mclk);
        xfer.valid <= 1'b0;
    endtask : send
    always @(negedge mclk) begin
        exp_type e;
        if (xpend) check("xfer", xq.pop_front(), mod3_err_q);
        xpend = xfer.valid;
        if (done_q === 1'b1) begin
            check("queue", 1, eq.size() != 0);
            e = eq.pop_front();
            check("result", e.res, result_q);
            check("cycles", e.cyc, mem_cycles_q);
            if (e.op == excess3_pkg::op_div)
                check("quot", e.quo, second_arith_register_q);
            if (e.op < excess3_pkg::op_mul)
                check("recomp", e.rc, recomp_q);
            if (e.cyc == 6'h00)
                check("mod3_err", e.err, mod3_err_q);
        end
    end
    // ****************
    // sequence and verdict
    // ****************
    task automatic give_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #300000;
        errors++;
        give_verdict();
    end
    initial begin
        excess3_pkg::req_type r;
        int s;
        s = $urandom(32'h4888);
        rstn <= 1'b0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        r = '0;
        r.valid = 1'b1;
        r.op = excess3_pkg::op_mul;
        r.reg_word = mk(1'b0, 24'hc785a3);
        issue(r);
        r.reg_word = mk(1'b0, 24'h3cccc8);
        issue(r);
        r.op = excess3_pkg::op_div;
        r.quotient = 24'hb397c4;
        issue(r);
        // later half mixes in non-numeric codes on both operands
        for (int k = 0; k < 48; k++) begin
            r.op = excess3_pkg::op_type'(k % 4);
            r.quotient = nd();
            r.reg_word = mk(1'($urandom), k < 24 ? nd() : 24'($urandom));
            r.mem_word = mk(1'($urandom), k < 24 ? nd() : 24'($urandom));
            issue(r);
        end
        @(posedge mclk);
        cmd.valid <= 1'b0;
        repeat (6) @(posedge mclk);
        for (int k = 0; k < 16; k++) send(27'($urandom));
        repeat (6) @(posedge mclk);
        check("pending", 0, eq.size());
        give_verdict();
    end
endmodule : excess3_arith_mod3_check_test
